//--- logic/hbpb_map.svh
// Constants for the Harvard bus priority bridge: class indices, frame decode, timing.
`ifndef HBPB_MAP_SVH
`define HBPB_MAP_SVH

// ****************************************************************
// Request classes, highest priority at index 0
// ****************************************************************
`define HBPB_CLS_DW      0
`define HBPB_CLS_PW      1
`define HBPB_CLS_DR      2
`define HBPB_CLS_PR      3
`define HBPB_CLS_FE      4
`define HBPB_NCLS        5

// ****************************************************************
// Peripheral frame decode on address bits 31:12
// ****************************************************************
`define HBPB_PF1_PAGE    20'h00006
`define HBPB_PF2_PAGE    20'h00007
`define HBPB_FCH_PAD     10'h000

// ****************************************************************
// Peripheral wait states, counted in clk cycles
// ****************************************************************
`define HBPB_PF_WR_WAIT  2'h0
`define HBPB_PF_RD_WAIT  2'h2

`endif

//--- logic/hbpb_pkg.sv
// Types shared by the Harvard bus priority bridge.
package hbpb_pkg;

    typedef logic [4:0] hbpb_cls_t;

    typedef enum logic [1:0] {
        HBPB_PB_IDLE,
        HBPB_PB_XFER,
        HBPB_PB_STALL
    } hbpb_pb_state_t;

endpackage

//--- logic/hbpb_prio_arb.sv
// Fixed-priority one-hot arbiter over the five request classes.
`timescale 1ns/1ps
`include "hbpb_map.svh"
module hbpb_prio_arb (
    // Requests, bit 0 highest
    input  wire hbpb_pkg::hbpb_cls_t req,
    // One-hot grant
    output      hbpb_pkg::hbpb_cls_t gnt
);
    genvar i;
    generate
        for (i = 0; i < `HBPB_NCLS; i++) begin : g_gnt
            if (i == 0) begin : g_top
                assign gnt[i] = req[i];
            end else begin : g_rest
                // Lower index wins, so a loser waits for every class above it
                assign gnt[i] = req[i] & ~|req[i-1:0];
            end
        end
    endgenerate
endmodule

//--- logic/hbpb_bridge.sv
// Harvard bus priority bridge: memory port arbitration and peripheral frame bridge.
//
// Behaviour
// - Fetch bus carries a 22-bit address and 32-bit data word.
// - Read and write buses each have independent 32-bit address and data.
// - A 32-bit data transfer goes to memory as one single access.
// - At most two of fetch, data read and data write proceed in one cycle: one at memory, one on the peripheral bus.
// - Collisions served: data write, program write, data read, program read, fetch.
// - Read and write buses merge onto one peripheral bus; fetch never reaches it.
// - Peripheral bus has 16-bit address and 16 or 32-bit data.
// - Second peripheral frame takes only 16-bit transfers.
// - First peripheral frame takes 16-bit and 32-bit transfers.
// - First frame: writes zero wait, reads two wait, ready may stretch.
// - Back-to-back first frame writes incur a one-cycle stall.
// - Second frame: writes zero wait, reads two wait, never stretched.
// - Protected write then read elsewhere reaches the bus in order, aligned.
`timescale 1ns/1ps
`include "hbpb_map.svh"
module hbpb_bridge (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // Protection mode
    input  wire logic        prot_en,
    // Fetch bus
    input  wire logic        fch_req,
    input  wire logic [21:0] fch_addr,
    output      logic        fch_ack,
    output      logic [31:0] fch_rdata,
    // Read bus
    input  wire logic        rd_req,
    input  wire logic        rd_prog,
    input  wire logic        rd_wide,
    input  wire logic [31:0] rd_addr,
    output      logic        rd_ack,
    output      logic [31:0] rd_rdata,
    // Write bus
    input  wire logic        wr_req,
    input  wire logic        wr_prog,
    input  wire logic        wr_wide,
    input  wire logic [31:0] wr_addr,
    input  wire logic [31:0] wr_data,
    output      logic        wr_ack,
    // Memory port
    output      logic        mem_en,
    output      logic        mem_we,
    output      logic        mem_prog,
    output      logic        mem_wide,
    output      logic [31:0] mem_addr,
    output      logic [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    // Peripheral bus
    output      logic        pb_sel1,
    output      logic        pb_sel2,
    output      logic        pb_we,
    output      logic        pb_wide,
    output      logic [15:0] pb_addr,
    output      logic [31:0] pb_wdata,
    input  wire logic [31:0] pb_rdata,
    input  wire logic        pb_ready
);

    // ****************************************************************
    // Class decode
    // ****************************************************************
    hbpb_pkg::hbpb_cls_t      cls_req;
    hbpb_pkg::hbpb_cls_t      cls_wr;
    hbpb_pkg::hbpb_cls_t      cls_prog;
    hbpb_pkg::hbpb_cls_t      cls_wide;
    hbpb_pkg::hbpb_cls_t      cls_pb;
    hbpb_pkg::hbpb_cls_t      cls_pf1;
    hbpb_pkg::hbpb_cls_t      pending;
    hbpb_pkg::hbpb_cls_t      mem_vec;
    hbpb_pkg::hbpb_cls_t      pb_vec;
    hbpb_pkg::hbpb_cls_t      mem_gnt;
    hbpb_pkg::hbpb_cls_t      pb_win;
    hbpb_pkg::hbpb_cls_t      pb_gnt;
    hbpb_pkg::hbpb_cls_t      mem_done;
    hbpb_pkg::hbpb_cls_t      pb_done;
    hbpb_pkg::hbpb_cls_t      done_cls;
    hbpb_pkg::hbpb_cls_t      issued_reg;
    hbpb_pkg::hbpb_cls_t      ack_cls_reg;
    hbpb_pkg::hbpb_cls_t      mem_cls_reg;
    hbpb_pkg::hbpb_cls_t      pb_cls_reg;
    hbpb_pkg::hbpb_pb_state_t pb_state_reg;
    logic [31:0]              cls_addr [`HBPB_NCLS];
    logic [31:0]              m_addr;
    logic [31:0]              p_addr;
    logic [31:0]              p_wdata;
    logic [1:0]               wait_cnt_reg;
    logic                     p_we;
    logic                     p_pf1;
    logic                     p_wide;
    logic                     pb_fin;
    logic                     need_stall;
    logic                     pb_free;

    // Shared write data; program and data writes share one bus
    assign cls_req[`HBPB_CLS_DW]  = wr_req & ~wr_prog;
    assign cls_req[`HBPB_CLS_PW]  = wr_req & wr_prog;
    assign cls_req[`HBPB_CLS_DR]  = rd_req & ~rd_prog;
    assign cls_req[`HBPB_CLS_PR]  = rd_req & rd_prog;
    assign cls_req[`HBPB_CLS_FE]  = fch_req;
    assign cls_addr[`HBPB_CLS_DW] = wr_addr;
    assign cls_addr[`HBPB_CLS_PW] = wr_addr;
    assign cls_addr[`HBPB_CLS_DR] = rd_addr;
    assign cls_addr[`HBPB_CLS_PR] = rd_addr;
    assign cls_addr[`HBPB_CLS_FE] = {`HBPB_FCH_PAD, fch_addr};
    assign cls_wr                 = 5'h03;
    assign cls_prog               = 5'h0A;
    assign cls_wide               = {1'b1, rd_wide, rd_wide, wr_wide, wr_wide};

    genvar c;
    generate
        for (c = 0; c < `HBPB_NCLS; c++) begin : g_cls
            assign cls_pf1[c] = (c != `HBPB_CLS_FE) && (cls_addr[c][31:12] == `HBPB_PF1_PAGE);
            assign cls_pb[c]  = (c != `HBPB_CLS_FE) &&
                                ((cls_addr[c][31:12] == `HBPB_PF1_PAGE) ||
                                 (cls_addr[c][31:12] == `HBPB_PF2_PAGE));
        end
    endgenerate

    // ****************************************************************
    // Arbitration per target
    // ****************************************************************
    // Requests stay visible until acked, so a loser simply competes again
    assign pending = cls_req & ~issued_reg & ~ack_cls_reg;
    assign mem_vec = pending & ~cls_pb;
    assign pb_vec  = pending & cls_pb;

    hbpb_prio_arb u_mem_arb (
        .req (mem_vec),
        .gnt (mem_gnt)
    );

    hbpb_prio_arb u_pb_arb (
        .req (pb_vec),
        .gnt (pb_win)
    );

    always_comb begin
        m_addr = 32'h00000000;
        p_addr = 32'h00000000;
        for (int i = 0; i < `HBPB_NCLS; i++) begin
            if (mem_gnt[i]) begin
                m_addr = cls_addr[i];
            end
            if (pb_win[i]) begin
                p_addr = cls_addr[i];
            end
        end
    end

    assign p_we    = |(pb_win & cls_wr);
    assign p_pf1   = |(pb_win & cls_pf1);
    assign p_wide  = |(pb_win & cls_wide) & p_pf1;
    assign p_wdata = p_wide ? wr_data : {16'h0000, wr_data[15:0]};

    // ****************************************************************
    // Peripheral handshake and stall decisions
    // ****************************************************************
    // Frame 2 ignores ready, so a stuck peripheral cannot hang it
    assign pb_fin  = (pb_state_reg == hbpb_pkg::HBPB_PB_XFER) && (wait_cnt_reg == 2'h0) &&
                     (pb_sel2 | pb_ready);
    assign need_stall = pb_fin && (|pb_win) && pb_we &&
                        ((pb_sel1 && p_we && p_pf1) ||
                         (prot_en && !p_we && (p_addr[15:0] != pb_addr)));
    // Stall cycle may grant, so the gap is exactly one cycle
    assign pb_free = ((pb_state_reg == hbpb_pkg::HBPB_PB_IDLE) ||
                      (pb_state_reg == hbpb_pkg::HBPB_PB_STALL) || pb_fin) && !need_stall;
    assign pb_gnt  = pb_free ? pb_win : 5'h00;
    assign pb_done = pb_fin ? pb_cls_reg : 5'h00;
    assign mem_done = mem_en ? mem_cls_reg : 5'h00;
    assign done_cls = mem_done | pb_done;

    // ****************************************************************
    // Outstanding tracking
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            issued_reg  <= 5'h00;
            ack_cls_reg <= 5'h00;
            fch_ack     <= 1'b0;
            rd_ack      <= 1'b0;
            wr_ack      <= 1'b0;
        end else if (ce) begin
            issued_reg  <= (issued_reg | mem_gnt | pb_gnt) & ~done_cls;
            ack_cls_reg <= done_cls;
            fch_ack     <= done_cls[`HBPB_CLS_FE];
            rd_ack      <= done_cls[`HBPB_CLS_DR] | done_cls[`HBPB_CLS_PR];
            wr_ack      <= done_cls[`HBPB_CLS_DW] | done_cls[`HBPB_CLS_PW];
        end
    end

    // ****************************************************************
    // Read data return
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fch_rdata <= 32'h00000000;
            rd_rdata  <= 32'h00000000;
        end else if (ce) begin
            if (mem_done[`HBPB_CLS_FE]) begin
                fch_rdata <= mem_rdata;
            end
            if (mem_done[`HBPB_CLS_DR] | mem_done[`HBPB_CLS_PR]) begin
                rd_rdata <= mem_rdata;
            end else if (pb_done[`HBPB_CLS_DR] | pb_done[`HBPB_CLS_PR]) begin
                rd_rdata <= pb_wide ? pb_rdata : {16'h0000, pb_rdata[15:0]};
            end
        end
    end

    // ****************************************************************
    // Memory port, one zero-wait access per cycle
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_en      <= 1'b0;
            mem_we      <= 1'b0;
            mem_prog    <= 1'b0;
            mem_wide    <= 1'b0;
            mem_addr    <= 32'h00000000;
            mem_wdata   <= 32'h00000000;
            mem_cls_reg <= 5'h00;
        end else if (ce) begin
            mem_en      <= |mem_gnt;
            mem_cls_reg <= mem_gnt;
            if (|mem_gnt) begin
                mem_we    <= |(mem_gnt & cls_wr);
                mem_prog  <= |(mem_gnt & cls_prog);
                mem_wide  <= |(mem_gnt & cls_wide);
                mem_addr  <= m_addr;
                mem_wdata <= wr_data;
            end
        end
    end

    // ****************************************************************
    // Peripheral bridge state machine
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pb_state_reg <= hbpb_pkg::HBPB_PB_IDLE;
            wait_cnt_reg <= 2'h0;
            pb_cls_reg   <= 5'h00;
            pb_sel1      <= 1'b0;
            pb_sel2      <= 1'b0;
            pb_we        <= 1'b0;
            pb_wide      <= 1'b0;
            pb_addr      <= 16'h0000;
            pb_wdata     <= 32'h00000000;
        end else if (ce) begin
            case (pb_state_reg)
                hbpb_pkg::HBPB_PB_IDLE,
                hbpb_pkg::HBPB_PB_STALL,
                hbpb_pkg::HBPB_PB_XFER: begin
                    if (pb_state_reg == hbpb_pkg::HBPB_PB_XFER && !pb_fin) begin
                        if (wait_cnt_reg != 2'h0) begin
                            wait_cnt_reg <= wait_cnt_reg - 2'h1;
                        end
                    end else if (|pb_gnt) begin
                        pb_state_reg <= hbpb_pkg::HBPB_PB_XFER;
                        wait_cnt_reg <= p_we ? `HBPB_PF_WR_WAIT : `HBPB_PF_RD_WAIT;
                        pb_cls_reg   <= pb_gnt;
                        pb_sel1      <= p_pf1;
                        pb_sel2      <= ~p_pf1;
                        pb_we        <= p_we;
                        pb_wide      <= p_wide;
                        pb_addr      <= p_addr[15:0];
                        pb_wdata     <= p_wdata;
                    end else if (need_stall) begin
                        pb_state_reg <= hbpb_pkg::HBPB_PB_STALL;
                        pb_sel1      <= 1'b0;
                        pb_sel2      <= 1'b0;
                    end else begin
                        pb_state_reg <= hbpb_pkg::HBPB_PB_IDLE;
                        pb_sel1      <= 1'b0;
                        pb_sel2      <= 1'b0;
                    end
                end
                default: begin
                    pb_state_reg <= hbpb_pkg::HBPB_PB_IDLE;
                    pb_sel1      <= 1'b0;
                    pb_sel2      <= 1'b0;
                end
            endcase
        end
    end

endmodule

//--- testbench/hbpb_bridge_sva.sv
// Port-level assertions for the Harvard bus priority bridge.
`timescale 1ns/1ps
`include "hbpb_map.svh"
module hbpb_bridge_sva (
    // Clock, reset, mode
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        prot_en,
    // Core buses
    input wire logic [21:0] fch_addr,
    input wire logic        fch_ack,
    input wire logic [31:0] fch_rdata,
    input wire logic [31:0] rd_addr,
    input wire logic        rd_wide,
    input wire logic        rd_ack,
    input wire logic [31:0] rd_rdata,
    input wire logic        wr_req,
    input wire logic        wr_wide,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_ack,
    // Memory and peripheral side
    input wire logic        mem_en,
    input wire logic        mem_we,
    input wire logic        mem_wide,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic        pb_sel1,
    input wire logic        pb_sel2,
    input wire logic        pb_we,
    input wire logic        pb_wide,
    input wire logic [15:0] pb_addr,
    input wire logic [31:0] pb_wdata,
    input wire logic [31:0] pb_rdata,
    input wire logic        pb_ready
);
    // ****************
    // Checks
    // ****************
    wire logic rd_mem = rd_addr[31:12] != `HBPB_PF1_PAGE && rd_addr[31:12] != `HBPB_PF2_PAGE;
    wire logic wr_mem = wr_addr[31:12] != `HBPB_PF1_PAGE && wr_addr[31:12] != `HBPB_PF2_PAGE;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    AST_FCH_BUS: assert property (fch_ack |-> $past(mem_en) && $past(mem_addr) == {10'h000, fch_addr}
        && fch_rdata == $past(mem_rdata)) else $error("fetch path");
    AST_RD_MEM: assert property (rd_ack && rd_mem |-> $past(mem_en && !mem_we) && $past(mem_addr) == rd_addr
        && $past(mem_wide) == rd_wide && rd_rdata == $past(mem_rdata)) else $error("read path");
    AST_WR_MEM: assert property (wr_ack && wr_mem |-> $past(mem_en && mem_we) && $past(mem_addr) == wr_addr
        && $past(mem_wdata) == wr_data) else $error("write path");
    AST_WR_FIRST: assert property (mem_en && !mem_we |->
        !$past(wr_req && wr_mem && !wr_ack && !(mem_en && mem_we))) else $error("write passed over");
    AST_PF2_NARROW: assert property (pb_sel2 |-> !pb_wide && pb_wdata[31:16] == 16'h0000)
        else $error("wide frame2");
    AST_PF1_WR: assert property (pb_sel1 && pb_we |-> pb_wide == wr_wide && pb_addr == wr_addr[15:0]
        && pb_wdata == (wr_wide ? wr_data : {16'h0000, wr_data[15:0]})) else $error("frame1 write");
    AST_PF2_WR: assert property (pb_sel2 && pb_we |=> wr_ack && !(pb_sel2 && pb_we)) else $error("frame2 write");
    AST_PF2_RD: assert property ($rose(pb_sel2) && !pb_we |-> (pb_sel2 && !pb_we)[*3] ##1
        (rd_ack && rd_rdata[15:0] == $past(pb_rdata[15:0]))) else $error("frame2 read");
    AST_PF1_HOLD: assert property (pb_sel1 && !pb_ready |=> pb_sel1 && $stable(pb_addr)) else $error("stretch");
    AST_PF1_B2B: assert property (pb_sel1 && pb_we && pb_ready |=> !(pb_sel1 && pb_we)) else $error("no stall");
    AST_PROT: assert property (prot_en && pb_we && (pb_sel2 || pb_sel1 && pb_ready) |=>
        !((pb_sel1 || pb_sel2) && !pb_we && pb_addr != $past(pb_addr))) else $error("order");
    cover property (rd_ack && rd_mem);
    cover property (pb_sel1 && !pb_ready);
    cover property ($rose(pb_sel2) && !pb_we);
endmodule
bind hbpb_bridge hbpb_bridge_sva chk (.*);

//--- testbench/hbpb_far.sv
// Behavioural memory and peripheral frames facing the bridge.
`timescale 1ns/1ps
module hbpb_far (
    // Clock and pacing
    input  wire logic        clk,
    input  wire logic        slow,
    // Memory port
    input  wire logic        mem_en,
    input  wire logic [31:0] mem_addr,
    output      logic [31:0] mem_rdata,
    // Peripheral bus
    input  wire logic        pb_sel1,
    input  wire logic        pb_sel2,
    input  wire logic [15:0] pb_addr,
    output      logic [31:0] pb_rdata,
    output      logic        pb_ready
);
    logic [31:0] cnt_reg = 32'h0000_0000;
    always_ff @(posedge clk) cnt_reg <= cnt_reg + 32'h0000_0001;
    // Idle lines wander so stale data cannot pass
    assign mem_rdata = mem_en ? mem_addr ^ 32'hA5A5_0F0F : cnt_reg;
    assign pb_rdata  = (pb_sel1 || pb_sel2) ? {pb_addr, ~pb_addr} : ~cnt_reg;
    // Ready toggles in frame2 too, which must ignore it
    assign pb_ready  = !slow || cnt_reg[1:0] == 2'h3;
endmodule

//--- testbench/hbpb_bridge_tb.sv
// Self-checking bench for the Harvard bus priority bridge.
`timescale 1ns/1ps
`include "hbpb_map.svh"
module hbpb_bridge_tb;
    logic        clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, prot_en = 1'b0, slow = 1'b0;
    logic        fch_req = 1'b0, rd_req = 1'b0, rd_prog = 1'b0, rd_wide = 1'b0;
    logic        wr_req = 1'b0, wr_prog = 1'b0, wr_wide = 1'b0;
    logic [21:0] fch_addr = 22'h00_0000;
    logic [31:0] rd_addr = 32'h0000_0000, wr_addr = 32'h0000_0000, wr_data = 32'h0000_0000, a;
    logic        fch_ack, rd_ack, wr_ack, mem_en, mem_we, mem_prog, mem_wide;
    logic        pb_sel1, pb_sel2, pb_we, pb_wide, pb_ready;
    logic [31:0] fch_rdata, rd_rdata, mem_addr, mem_wdata, mem_rdata, pb_wdata, pb_rdata;
    logic [15:0] pb_addr, seed = 16'h0054;
    int          mismatches = 0, comparisons = 0, n1, n2, n3;
    time         t_wr, t_rd, t_fch;
    hbpb_bridge uut (.*);
    hbpb_far mem_side (.*);
    always #4 clk = ~clk;
    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic pf(input logic [31:0] x);
        return x[31:12] == `HBPB_PF1_PAGE || x[31:12] == `HBPB_PF2_PAGE;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic await(ref logic ack, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack !== 1'b1 && n < 60);
        chk({31'h0, ack}, 32'h1);
    endtask
    task automatic do_fch(input logic [21:0] x, output int n);
        @(posedge clk);
        #1;
        fch_req = 1'b1;
        fch_addr = x;
        await(fch_ack, n);
        t_fch = $time;
        chk(fch_rdata, {10'h000, x} ^ 32'hA5A5_0F0F);
        @(posedge clk);
        #1;
        fch_req = 1'b0;
    endtask
    task automatic do_rd(input logic [31:0] x, input logic w, output int n);
        @(posedge clk);
        #1;
        rd_req = 1'b1;
        rd_addr = x;
        rd_wide = w;
        rd_prog = 1'b0;
        await(rd_ack, n);
        t_rd = $time;
        if (pf(x)) chk({16'h0000, rd_rdata[15:0]}, {16'h0000, ~x[15:0]});
        else chk(rd_rdata, x ^ 32'hA5A5_0F0F);
        @(posedge clk);
        #1;
        rd_req = 1'b0;
    endtask
    task automatic do_wr(input logic [31:0] x, input logic [31:0] d, input logic w, input logic p, output int n);
        @(posedge clk);
        #1;
        wr_req = 1'b1;
        wr_addr = x;
        wr_data = d;
        wr_wide = w;
        wr_prog = p;
        await(wr_ack, n);
        t_wr = $time;
        @(posedge clk);
        #1;
        wr_req = 1'b0;
    endtask
    task automatic conclude();
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        // All three buses collide at memory
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            fork
                do_wr({16'h8000, seed}, {seed, ~seed}, 1'b1, p[0], n1);
                do_rd({16'h4000, seed}, 1'b1, n2);
                do_fch({6'h00, seed}, n3);
            join
            chk({31'h0, t_wr < t_rd && t_rd < t_fch}, 32'h1);
        end
        // Distinct targets run side by side
        fork
            do_fch(22'h00_1234, n3);
            do_rd({`HBPB_PF2_PAGE, 12'h010}, 1'b1, n2);
            do_wr({`HBPB_PF1_PAGE, 12'h020}, 32'hCAFE_1234, 1'b1, 1'b0, n1);
        join
        chk(n3, 32'h2);
        // Random mix of targets, pacing and protection
        repeat (40) begin
            seed = lfsr(seed);
            slow = seed[0];
            prot_en = seed[1];
            a[31:12] = seed[3:2] == 2'h0 ? {4'h8, seed} : (seed[2] ? `HBPB_PF2_PAGE : `HBPB_PF1_PAGE);
            a[11:0] = seed[15:4];
            fork
                do_wr(a, {~seed, seed}, seed[6], 1'b0, n1);
                do_rd(a ^ 32'h0000_0004, seed[7], n2);
                do_fch({6'h00, seed}, n3);
            join
            chk({31'h0, t_wr < t_rd}, 32'h1);
        end
        conclude();
    end
endmodule
